/* File: lu_system_pins.sv */
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/10ps
// Notes on behaviour
// - With the enhanced-feature strap low the pattern status pin is not driven.
// - Receive outputs change on the falling recovered-clock edge for invert strap 0 or 1, rising for float.
// - While signal is lost the receive clock output follows the selected master clock.
// - Monitor strap 0 disables preamp and receive jitter attenuator, 1 enables preamp only, float enables only the attenuator.
// - In bipolar mode the negative receive output pulses for each negative mark.
// - With the decoder on, the violation output is high for one recovered-clock period per violation.
// - In bipolar mode the positive receive output pulses for each positive mark.
// - With the decoder on, the decoded NRZ stream appears on the positive output.
// - Transmit inputs are sampled on the rising transmit-clock edge for invert strap 0, falling otherwise.
// - Data-select straps choose the transmit source only when the enhanced-feature strap is 1.
// - A master clock pin held low forces data-select bit 1 low and hands that pin to the oscillator.
// - Mode strap 0 selects E3 and 1 selects DS3.
// - Data-select pair and mode strap pick normal, all ones, 1010, AIS, 2^23-1 or 2^15-1 data.
// - Pattern status is high while unsynchronised, else low with a high pulse per bit error.
// - Signal lost after the set count of zeros, restored after that many clocks free of zero runs.
module lu_system_pins
  import lu_pkg::*;
#(
  parameter int TX_FIFO_DEPTH = LU_TX_FIFO_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] enhanced_feature_strap,
  input wire logic [1:0] clock_edge_invert_strap,
  input wire logic [1:0] receive_monitor_strap,
  input wire logic [1:0] line_mode_strap,
  input wire logic [1:0] data_select_bit1,
  input wire logic [1:0] data_select_bit0,
  input wire logic zero_suppression_strap,
  input wire logic master_clock_in,
  input wire logic transmit_clock_in,
  input wire logic transmit_positive_in,
  input wire logic transmit_negative_in,
  input wire logic rx_line_clock,
  input wire logic rx_line_pos,
  input wire logic rx_line_neg,
  output logic receive_clock_out,
  output logic receive_positive_pulse,
  output logic receive_negative_pulse,
  output logic signal_lost_flag_n,
  output logic pattern_status_out,
  output logic pattern_status_oe,
  output logic oscillator_select_pin,
  output logic monitor_preamp_enable,
  output logic rx_jitter_atten_enable,
  output lu_mode_t line_mode,
  output logic tx_line_pos,
  output logic tx_line_neg
);

  // Pin synchronisers; only the second stage is read
  logic [19:0] sync1;
  logic [19:0] sync2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {enhanced_feature_strap, clock_edge_invert_strap, receive_monitor_strap,
                line_mode_strap, data_select_bit1, data_select_bit0, zero_suppression_strap,
                master_clock_in, transmit_clock_in, transmit_positive_in, transmit_negative_in,
                rx_line_clock, rx_line_pos, rx_line_neg};
      sync2 <= sync1;
    end
  end

  lu_strap_t feat_s, inv_s, mon_s, mode_s, ds1_s, ds0_s;
  logic zcs_high, mclk_s, txclk_s, txpos_s, txneg_s, rxclk_s, rxpos_s, rxneg_s;
  assign feat_s = lu_strap(sync2[19:18]);
  assign inv_s = lu_strap(sync2[17:16]);
  assign mon_s = lu_strap(sync2[15:14]);
  assign mode_s = lu_strap(sync2[13:12]);
  assign ds1_s = lu_strap(sync2[11:10]);
  assign ds0_s = lu_strap(sync2[9:8]);
  assign {zcs_high, mclk_s, txclk_s, txpos_s, txneg_s, rxclk_s, rxpos_s, rxneg_s} = sync2[7:0];

  logic mclk_prev, txclk_prev, rxclk_prev, master_prev;
  logic master_level, master_rise, txclk_rise, txclk_fall, rx_rise;
  assign txclk_rise = txclk_s && !txclk_prev;
  assign txclk_fall = !txclk_s && txclk_prev;
  assign rx_rise = rxclk_s && !rxclk_prev;
  assign master_rise = master_level && !master_prev;

  // Master clock source from pin activity
  logic [7:0] mclk_idle;
  logic [7:0] osc_count;
  logic osc_level;
  lu_mclk_src_t mclk_src;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {mclk_prev, txclk_prev, rxclk_prev, master_prev} <= 4'h0;
      mclk_idle <= 8'hff;
      osc_count <= 8'h00;
      osc_level <= 1'b0;
    end else begin
      {mclk_prev, txclk_prev, rxclk_prev, master_prev} <= {mclk_s, txclk_s, rxclk_s, master_level};
      if (mclk_s != mclk_prev) begin
        mclk_idle <= 8'h00;
      end else if (mclk_idle != 8'hff) begin
        mclk_idle <= mclk_idle + 8'h01;
      end
      if (osc_count >= 8'(LU_OSC_HALF_CYCLES - 1)) begin
        osc_count <= 8'h00;
        osc_level <= !osc_level;
      end else begin
        osc_count <= osc_count + 8'h01;
      end
    end
  end

  always_comb begin
    if (mclk_idle < 8'(LU_MCLK_IDLE_CYCLES)) begin
      mclk_src = LU_MCLK_PIN;
    end else if (mclk_s) begin
      mclk_src = LU_MCLK_TXCLK;
    end else begin
      mclk_src = LU_MCLK_OSC;
    end
  end

  always_comb begin
    unique case (mclk_src)
      LU_MCLK_PIN: master_level = mclk_s;
      LU_MCLK_TXCLK: master_level = txclk_s;
      default: master_level = osc_level;
    endcase
  end

  logic ds1_hi, ds0_hi;
  assign oscillator_select_pin = (mclk_src == LU_MCLK_OSC);
  assign ds1_hi = (ds1_s == LU_HIGH) && !oscillator_select_pin;
  assign ds0_hi = (ds0_s == LU_HIGH);
  assign monitor_preamp_enable = (mon_s == LU_HIGH);
  assign rx_jitter_atten_enable = (mon_s == LU_FLOAT);
  assign pattern_status_oe = (feat_s == LU_HIGH);

  always_comb begin
    unique case (mode_s)
      LU_LOW: line_mode = LU_MODE_E3;
      LU_HIGH: line_mode = LU_MODE_DS3;
      default: line_mode = LU_MODE_STS1;
    endcase
  end

  lu_tx_src_t tx_src;
  always_comb begin
    tx_src = LU_SRC_NORMAL;
    if (feat_s == LU_HIGH) begin
      unique case ({ds1_hi, ds0_hi})
        2'b00: tx_src = LU_SRC_NORMAL;
        2'b01: tx_src = LU_SRC_ONES;
        2'b10: tx_src = (mode_s == LU_HIGH) ? LU_SRC_AIS : LU_SRC_ALT;
        2'b11: tx_src = (mode_s == LU_LOW) ? LU_SRC_PRBS23 : LU_SRC_PRBS15;
      endcase
    end
  end

  // Transmit capture; a full buffer drops the bit and flags overflow
  logic tx_take, fifo_in_ready, fifo_out_valid;
  logic [LU_TX_WORD_W-1:0] fifo_out_data;
  assign tx_take = (inv_s == LU_LOW) ? txclk_rise : txclk_fall;

  lu_fifo #(
    .WIDTH(LU_TX_WORD_W),
    .DEPTH(TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(tx_take),
    .in_ready(fifo_in_ready),
    .in_data({txpos_s, txneg_s}),
    .out_valid(fifo_out_valid),
    .out_ready(master_rise),
    .out_data(fifo_out_data)
  );

  logic alt_bit, ami_neg, gen_mark, prbs_fb;
  logic [7:0] ais_count;
  logic [22:0] lfsr;
  always_comb begin
    if (tx_src == LU_SRC_PRBS23) begin
      prbs_fb = (lfsr[22] ^ lfsr[17]) | (lfsr == 23'h000000);
    end else begin
      prbs_fb = (lfsr[14] ^ lfsr[13]) | (lfsr[14:0] == 15'h0000);
    end
  end

  always_comb begin
    unique case (tx_src)
      LU_SRC_NORMAL: gen_mark = fifo_out_valid && fifo_out_data[1];
      LU_SRC_ONES: gen_mark = 1'b1;
      LU_SRC_ALT: gen_mark = alt_bit;
      LU_SRC_AIS: gen_mark = (ais_count == 8'h00) ? 1'b0 : alt_bit;
      LU_SRC_PRBS23, LU_SRC_PRBS15: gen_mark = prbs_fb;
      default: gen_mark = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_bit <= 1'b1;
      ais_count <= 8'h00;
      lfsr <= 23'h7fffff;
      ami_neg <= 1'b0;
      tx_line_pos <= 1'b0;
      tx_line_neg <= 1'b0;
    end else if (master_rise) begin
      alt_bit <= !alt_bit;
      ais_count <= (ais_count >= 8'(LU_AIS_BLOCK_BITS - 1)) ? 8'h00 : ais_count + 8'h01;
      lfsr <= {lfsr[21:0], prbs_fb};
      if (tx_src == LU_SRC_NORMAL && zcs_high) begin
        tx_line_pos <= fifo_out_valid && fifo_out_data[1];
        tx_line_neg <= fifo_out_valid && fifo_out_data[0];
      end else begin
        tx_line_pos <= gen_mark && !ami_neg;
        tx_line_neg <= gen_mark && ami_neg;
        if (gen_mark) begin
          ami_neg <= !ami_neg;
        end
      end
    end
  end

  // Receive capture and bipolar violation check
  logic rx_mark, next_viol, last_mark_neg;
  logic rx_pos_bit, rx_neg_bit, rx_nrz_bit, rx_viol_bit;
  assign rx_mark = rxpos_s || rxneg_s;
  assign next_viol = !zcs_high && rx_mark && (last_mark_neg == rxneg_s);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {rx_pos_bit, rx_neg_bit, rx_nrz_bit, rx_viol_bit} <= 4'h0;
      last_mark_neg <= 1'b1;
    end else if (rx_rise) begin
      rx_pos_bit <= rxpos_s;
      rx_neg_bit <= rxneg_s;
      rx_nrz_bit <= rx_mark;
      rx_viol_bit <= next_viol;
      if (rx_mark) begin
        last_mark_neg <= rxneg_s;
      end
    end
  end

  logic [7:0] los_limit, zero_run, next_zero_run, clean_count, exz_len;
  assign next_zero_run = rx_mark ? 8'h00 : ((zero_run == 8'hff) ? 8'hff : zero_run + 8'h01);
  assign exz_len = (line_mode == LU_MODE_E3) ? LU_EXZ_RUN_E3 : LU_EXZ_RUN_T3;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_run <= 8'h00;
      clean_count <= 8'h00;
      signal_lost_flag_n <= 1'b1;
    end else if (rx_rise) begin
      zero_run <= next_zero_run;
      if (signal_lost_flag_n) begin
        clean_count <= 8'h00;
        if (next_zero_run >= los_limit) begin
          signal_lost_flag_n <= 1'b0;
        end
      end else if (next_zero_run >= exz_len) begin
        clean_count <= 8'h00;
      end else if (({1'b0, clean_count} + 9'h001) >= {1'b0, los_limit}) begin
        clean_count <= 8'h00;
        signal_lost_flag_n <= 1'b1;
      end else begin
        clean_count <= clean_count + 8'h01;
      end
    end
  end

  // Pattern detector; an all-zero stream also predicts cleanly, so SIGNAL_LOST_FLAG should be checked too
  lu_prbs_state_t prbs_state;
  logic [22:0] det;
  logic [5:0] match_run;
  logic [2:0] err_count;
  logic det_err, prbs_err_bit;
  always_comb begin
    if (line_mode == LU_MODE_E3) begin
      det_err = (det[22] ^ det[17]) != rx_mark;
    end else begin
      det_err = (det[14] ^ det[13]) != rx_mark;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prbs_state <= LU_PRBS_HUNT;
      det <= 23'h000000;
      match_run <= 6'h00;
      err_count <= 3'h0;
      prbs_err_bit <= 1'b0;
    end else if (rx_rise) begin
      det <= {det[21:0], rx_mark};
      prbs_err_bit <= (prbs_state == LU_PRBS_LOCK) && det_err;
      match_run <= (det_err || match_run == LU_PRBS_SYNC_MATCHES - 6'h01) ? 6'h00
                   : match_run + 6'h01;
      unique case (prbs_state)
        LU_PRBS_HUNT: begin
          if (!det_err && match_run == LU_PRBS_SYNC_MATCHES - 6'h01) begin
            prbs_state <= LU_PRBS_LOCK;
            err_count <= 3'h0;
          end
        end
        LU_PRBS_LOCK: begin
          if (det_err) begin
            if (err_count == LU_PRBS_LOSS_ERRORS - 3'h1) begin
              prbs_state <= LU_PRBS_HUNT;
            end
            err_count <= err_count + 3'h1;
          end else if (match_run == LU_PRBS_SYNC_MATCHES - 6'h01) begin
            err_count <= 3'h0;
          end
        end
        default: prbs_state <= LU_PRBS_HUNT;
      endcase
    end
  end

  // Receive clock and data outputs
  logic rclk_level, upd_edge;
  assign rclk_level = signal_lost_flag_n ? rxclk_s : master_level;
  assign upd_edge = (inv_s == LU_FLOAT) ? (rclk_level && !receive_clock_out)
                    : (!rclk_level && receive_clock_out);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_clock_out <= 1'b0;
      receive_positive_pulse <= 1'b0;
      receive_negative_pulse <= 1'b0;
      pattern_status_out <= 1'b1;
    end else begin
      receive_clock_out <= rclk_level;
      if (upd_edge) begin
        receive_positive_pulse <= zcs_high ? rx_pos_bit : rx_nrz_bit;
        receive_negative_pulse <= zcs_high ? rx_neg_bit : rx_viol_bit;
        pattern_status_out <= (prbs_state == LU_PRBS_HUNT) || prbs_err_bit;
      end
    end
  end

  // Register slave, zero wait states
  logic hit_status, hit_limit, hit_viol, wr_en, ovf_set, unf_set;
  logic tx_overflow, tx_underrun;
  logic [15:0] viol_count;
  logic [31:0] status_word, read_word;
  assign hit_status = (paddr == LU_REG_STATUS);
  assign hit_limit = (paddr == LU_REG_LOS_LIMIT);
  assign hit_viol = (paddr == LU_REG_VIOL_COUNT);
  assign pready = psel && penable;
  assign pslverr = psel && penable && !(hit_status || hit_limit || hit_viol);
  assign wr_en = psel && penable && pwrite;
  assign ovf_set = tx_take && !fifo_in_ready;
  assign unf_set = master_rise && (tx_src == LU_SRC_NORMAL) && !fifo_out_valid;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      los_limit <= LU_LOS_LIMIT_RESET;
      tx_overflow <= 1'b0;
      tx_underrun <= 1'b0;
    end else begin
      if (wr_en && hit_limit) begin
        los_limit <= pwdata[7:0];
      end
      // Hardware set wins over a simultaneous clear
      tx_overflow <= ovf_set || (tx_overflow && !(wr_en && hit_status && pwdata[LU_ST_OVERFLOW]));
      tx_underrun <= unf_set || (tx_underrun && !(wr_en && hit_status && pwdata[LU_ST_UNDERRUN]));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      viol_count <= 16'h0000;
    end else if (wr_en && hit_viol) begin
      viol_count <= {15'h0000, rx_rise && next_viol};
    end else if (rx_rise && next_viol && viol_count != 16'hffff) begin
      viol_count <= viol_count + 16'h0001;
    end
  end

  always_comb begin
    status_word = 32'h00000000;
    status_word[LU_ST_MODE_LSB +: 2] = line_mode;
    status_word[LU_ST_SRC_LSB +: 3] = tx_src;
    status_word[LU_ST_LOS] = !signal_lost_flag_n;
    status_word[LU_ST_PRBS_LOCK] = (prbs_state == LU_PRBS_LOCK);
    status_word[LU_ST_RX_JA] = rx_jitter_atten_enable;
    status_word[LU_ST_PREAMP] = monitor_preamp_enable;
    status_word[LU_ST_OVERFLOW] = tx_overflow;
    status_word[LU_ST_UNDERRUN] = tx_underrun;
    status_word[LU_ST_MCLK_LSB +: 2] = mclk_src;
    read_word = 32'h00000000;
    if (hit_status) begin
      read_word = status_word;
    end else if (hit_limit) begin
      read_word = {24'h000000, los_limit};
    end else if (hit_viol) begin
      read_word = {16'h0000, viol_count};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= read_word;
    end
  end

endmodule

/* File: lu_pkg.sv */
package lu_pkg;

  // Three-level strap pin as seen by the digital core
  typedef enum logic [1:0] {
    LU_LOW = 2'h0,
    LU_HIGH = 2'h1,
    LU_FLOAT = 2'h2,
    LU_BAD = 2'h3
  } lu_strap_t;

  typedef enum logic [1:0] {
    LU_MODE_E3 = 2'h0,
    LU_MODE_DS3 = 2'h1,
    LU_MODE_STS1 = 2'h2
  } lu_mode_t;

  typedef enum logic [2:0] {
    LU_SRC_NORMAL = 3'h0,
    LU_SRC_ONES = 3'h1,
    LU_SRC_ALT = 3'h2,
    LU_SRC_AIS = 3'h3,
    LU_SRC_PRBS23 = 3'h4,
    LU_SRC_PRBS15 = 3'h5
  } lu_tx_src_t;

  typedef enum logic [1:0] {
    LU_MCLK_PIN = 2'h0,
    LU_MCLK_TXCLK = 2'h1,
    LU_MCLK_OSC = 2'h2
  } lu_mclk_src_t;

  typedef enum logic [1:0] {
    LU_PRBS_HUNT = 2'b01,
    LU_PRBS_LOCK = 2'b10
  } lu_prbs_state_t;

  localparam int unsigned LU_PCLK_MHZ = 25;
  localparam int unsigned LU_MCLK_IDLE_NS = 2000;
  localparam int unsigned LU_MCLK_IDLE_CYCLES = (LU_MCLK_IDLE_NS * LU_PCLK_MHZ + 999) / 1000;
  localparam int unsigned LU_OSC_HALF_NS = 160;
  localparam int unsigned LU_OSC_HALF_CYCLES = (LU_OSC_HALF_NS * LU_PCLK_MHZ) / 1000;

  localparam logic [7:0] LU_LOS_LIMIT_RESET = 8'haf;
  localparam logic [7:0] LU_EXZ_RUN_E3 = 8'h04;
  localparam logic [7:0] LU_EXZ_RUN_T3 = 8'h03;
  localparam logic [5:0] LU_PRBS_SYNC_MATCHES = 6'h20;
  localparam logic [2:0] LU_PRBS_LOSS_ERRORS = 3'h4;
  localparam int unsigned LU_AIS_BLOCK_BITS = 85;
  localparam int unsigned LU_TX_WORD_W = 2;
  localparam int unsigned LU_TX_FIFO_DEPTH = 16;

  localparam logic [11:0] LU_REG_STATUS = 12'h000;
  localparam logic [11:0] LU_REG_LOS_LIMIT = 12'h004;
  localparam logic [11:0] LU_REG_VIOL_COUNT = 12'h008;

  localparam int unsigned LU_ST_MODE_LSB = 0;
  localparam int unsigned LU_ST_SRC_LSB = 2;
  localparam int unsigned LU_ST_LOS = 5;
  localparam int unsigned LU_ST_PRBS_LOCK = 6;
  localparam int unsigned LU_ST_RX_JA = 7;
  localparam int unsigned LU_ST_PREAMP = 8;
  localparam int unsigned LU_ST_OVERFLOW = 9;
  localparam int unsigned LU_ST_UNDERRUN = 10;
  localparam int unsigned LU_ST_MCLK_LSB = 11;

  // Unused code on a strap is read as float
  function automatic lu_strap_t lu_strap(input logic [1:0] code);
    return (code == 2'h3) ? LU_FLOAT : lu_strap_t'(code);
  endfunction

endpackage

/* File: lu_fifo.sv */
`timescale 1ns/10ps
module lu_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_shape
    $error("lu_fifo needs WIDTH of at least 1 and a power-of-two DEPTH of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + (AW+1)'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + (AW+1)'(1);
      end
    end
  end

endmodule

/* File: lu_chk.sv */
`timescale 1ns/10ps
module lu_chk
  import lu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] enhanced_feature_strap,
  input wire logic [1:0] clock_edge_invert_strap,
  input wire logic [1:0] receive_monitor_strap,
  input wire logic [1:0] line_mode_strap,
  input wire logic master_clock_in,
  input wire logic receive_clock_out,
  input wire logic receive_positive_pulse,
  input wire logic receive_negative_pulse,
  input wire logic pattern_status_oe,
  input wire logic oscillator_select_pin,
  input wire logic monitor_preamp_enable,
  input wire logic rx_jitter_atten_enable,
  input wire lu_mode_t line_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [6:0] mclk_low;
  // Saturates so a long low spell never wraps back to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mclk_low <= 7'h0;
    end else if (master_clock_in) begin
      mclk_low <= 7'h0;
    end else if (mclk_low != 7'h7f) begin
      mclk_low <= mclk_low + 7'h1;
    end
  end
  // Four samples leave room for the two-flop strap synchroniser
  a_status_off: assert property (
    (enhanced_feature_strap == 2'h0)[*4] |-> !pattern_status_oe) else $error("oe off");
  a_status_on: assert property (
    (enhanced_feature_strap == 2'h1)[*4] |-> pattern_status_oe) else $error("oe on");
  a_mode_ds3: assert property (
    (line_mode_strap == 2'h1)[*4] |-> line_mode == LU_MODE_DS3) else $error("mode ds3");
  a_mode_float: assert property (
    (line_mode_strap == 2'h2)[*4] |-> line_mode == LU_MODE_STS1) else $error("mode sts1");
  a_monitor_preamp: assert property (
    (receive_monitor_strap == 2'h1)[*4] |-> monitor_preamp_enable && !rx_jitter_atten_enable)
    else $error("preamp");
  a_monitor_ja: assert property (
    (receive_monitor_strap == 2'h2)[*4] |-> !monitor_preamp_enable && rx_jitter_atten_enable)
    else $error("rx ja");
  a_osc_takeover: assert property (
    mclk_low == 7'h7f |-> oscillator_select_pin) else $error("osc");
  a_rx_fall_update: assert property (
    (clock_edge_invert_strap == 2'h0)[*4] ##0 $changed(receive_positive_pulse)
    |-> $fell(receive_clock_out)) else $error("rx fall");
  a_rx_rise_update: assert property (
    (clock_edge_invert_strap == 2'h2)[*4] ##0 $changed(receive_negative_pulse)
    |-> $rose(receive_clock_out)) else $error("rx rise");
  a_flag_width: assert property (
    $rose(receive_negative_pulse)
    |=> (receive_negative_pulse && $stable(receive_clock_out))[*3]) else $error("width");
  cover property ($rose(receive_negative_pulse));
  cover property ($rose(oscillator_select_pin));
  cover property ((clock_edge_invert_strap == 2'h2)[*4] ##0 $changed(receive_negative_pulse));
endmodule
bind lu_system_pins lu_chk u_chk (.*);

/* File: lu_framer_model.sv */
`timescale 1ns/10ps
module lu_framer_model (
  input wire logic start,
  input wire logic [7:0] nbits,
  output logic transmit_clock_in,
  output logic transmit_positive_in,
  output logic transmit_negative_in,
  output logic busy
);
  initial begin
    transmit_clock_in = 1'b0;
    transmit_positive_in = 1'b0;
    transmit_negative_in = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge start);
      busy = 1'b1;
      #7;
      for (int i = 0; i < nbits; i++) begin
        // Launched half a period ahead of the sampling rise
        transmit_positive_in = i[0];
        transmit_negative_in = !i[0];
        #160 transmit_clock_in = 1'b1;
        #160 transmit_clock_in = 1'b0;
      end
      // The released positive line toggles so a stale bit cannot pass for data
      transmit_positive_in = !transmit_positive_in;
      busy = 1'b0;
    end
  end
endmodule

/* File: test_lu_system_pins.sv */
`timescale 1ns/10ps
module test_lu_system_pins;
  import lu_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, zero_suppression_strap = 1, master_clock_in = 0, mclk_run = 1;
  logic [1:0] enhanced_feature_strap = 0, clock_edge_invert_strap = 0;
  logic [1:0] receive_monitor_strap = 0, line_mode_strap = 0;
  logic [1:0] data_select_bit1 = 0, data_select_bit0 = 0;
  logic rx_line_clock = 0, rx_line_pos = 0, rx_line_neg = 0, start = 0;
  logic transmit_clock_in, transmit_positive_in, transmit_negative_in, busy;
  logic receive_clock_out, receive_positive_pulse, receive_negative_pulse, signal_lost_flag_n;
  logic pattern_status_out, pattern_status_oe, oscillator_select_pin, tx_line_pos, tx_line_neg;
  logic monitor_preamp_enable, rx_jitter_atten_enable;
  lu_mode_t line_mode;
  int n_errors = 0, n_checks = 0, cyc = 0, np = 0, nn = 0, nr = 0;

  lu_system_pins uut (.*);
  lu_framer_model u_frm (.nbits(8'h28), .*);

  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    // Slow master clock so the transmit buffer backs up
    if (mclk_run && cyc[3:0] == 0) master_clock_in <= ~master_clock_in;
    if ($rose(receive_positive_pulse)) np <= np + 1;
    if ($rose(receive_negative_pulse)) nn <= nn + 1;
    if ($changed(receive_clock_out)) nr <= nr + 1;
    if (cyc == 30000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rx_seq(input logic [7:0] p, input logic [7:0] n);
    for (int i = 7; i >= 0; i--) begin
      @(posedge pclk);
      rx_line_pos <= p[i];
      rx_line_neg <= n[i];
      rx_line_clock <= 0;
      wt(4);
      rx_line_clock <= 1;
      wt(3);
    end
  endtask

  task automatic t_regs();
    apb(0, LU_REG_LOS_LIMIT, 0);
    chk(rd, 32'haf, "los limit");
    chk(pattern_status_oe, 0, "oe");
    chk(pattern_status_out, 1, "hunting");
    apb(1, LU_REG_LOS_LIMIT, 32'h8);
    apb(0, LU_REG_LOS_LIMIT, 0);
    chk(rd, 32'h8, "los limit wr");
    apb(0, 12'h00c, 0);
    chk({rd[30:0], err}, 32'h1, "unmapped");
  endtask
  task automatic t_straps();
    int e;
    enhanced_feature_strap <= 1;
    for (int m = 0; m < 3; m++) begin
      line_mode_strap <= 2'(m);
      receive_monitor_strap <= 2'(m);
      for (int s = 0; s < 4; s++) begin
        data_select_bit1 <= {1'b0, s[1]};
        data_select_bit0 <= {1'b0, s[0]};
        wt(4);
        apb(0, LU_REG_STATUS, 0);
        e = !s[1] ? s[0] : !s[0] ? (m == 1 ? 3 : 2) : (m == 0 ? 4 : 5);
        chk(rd[4:2], e, "source");
      end
      chk(line_mode, m, "mode");
      chk({monitor_preamp_enable, rx_jitter_atten_enable}, {m == 1, m == 2}, "mon");
    end
    enhanced_feature_strap <= 0;
    wt(4);
    apb(0, LU_REG_STATUS, 0);
    chk(rd[4:2], 0, "straps ignored");
  endtask
  task automatic t_bipolar(input logic [1:0] c);
    int p0;
    int n0;
    clock_edge_invert_strap <= c;
    zero_suppression_strap <= 1;
    wt(4);
    p0 = np;
    n0 = nn;
    rx_seq(8'b10001000, 8'b00100100);
    wt(12);
    chk(np - p0, 2, "pos marks");
    chk(nn - n0, 2, "neg marks");
  endtask
  task automatic t_decoder();
    int p0;
    int n0;
    zero_suppression_strap <= 0;
    apb(1, LU_REG_VIOL_COUNT, 0);
    p0 = np;
    n0 = nn;
    rx_seq(8'b11000000, 8'h00);
    apb(0, LU_REG_VIOL_COUNT, 0);
    chk(rd, 1, "viol count");
    chk(nn - n0, 1, "viol flag");
    chk(np - p0, 1, "nrz");
  endtask
  task automatic t_los();
    int r0;
    enhanced_feature_strap <= 1;
    data_select_bit1 <= 1;
    data_select_bit0 <= 0;
    mclk_run <= 0;
    wt(1);
    master_clock_in <= 0;
    rx_seq(8'h00, 8'h00);
    wt(80);
    chk(signal_lost_flag_n, 0, "los");
    chk(oscillator_select_pin, 1, "osc pin");
    apb(0, LU_REG_STATUS, 0);
    chk({rd[12:11], rd[4:2]}, 5'h10, "osc src");
    r0 = nr;
    wt(40);
    chk(nr - r0 >= 6, 1, "rclk on master");
    rx_seq(8'haa, 8'h55);
    rx_seq(8'haa, 8'h55);
    chk(signal_lost_flag_n, 1, "los end");
  endtask
  task automatic t_tx();
    enhanced_feature_strap <= 0;
    zero_suppression_strap <= 1;
    clock_edge_invert_strap <= 0;
    mclk_run <= 1;
    wt(100);
    start <= 1;
    wt(2);
    while (busy) wt(1);
    apb(0, LU_REG_STATUS, 0);
    chk({rd[12:11], rd[9]}, 3'h1, "overflow");
    // Underrun is already set from idle time, so clear both flags first
    apb(1, LU_REG_STATUS, 32'h600);
    apb(0, LU_REG_STATUS, 0);
    chk(rd[10:9], 0, "w1c");
    chk(tx_line_pos ^ tx_line_neg, 1, "tx word");
    wt(800);
    apb(0, LU_REG_STATUS, 0);
    chk(rd[10], 1, "underrun");
    chk({tx_line_pos, tx_line_neg}, 0, "tx idle");
    mclk_run <= 0;
    wt(1);
    master_clock_in <= 1;
    wt(60);
    apb(0, LU_REG_STATUS, 0);
    chk(rd[12:11], 1, "transmit_clock_in master");
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_straps();
    t_bipolar(2'h0);
    t_bipolar(2'h2);
    t_decoder();
    t_los();
    t_tx();
    finish_test();
  end
endmodule
